/* rtl/boot_cfg_top.sv */
/*
  Boot configuration sequencer: waits out the strap hold window after reset,
  latches the synchronised strap levels, takes the fuse bits once the fuse
  array reports them valid, registers the decoded settings and exposes all of
  it on an APB slave. Assumes a 40 MHz pclk, an async active-low reset that
  stands for chip reset, and a fuse array whose valid level stays high.
*/
// Design decisions made here: the APB register port and the address map.
module boot_cfg_top
  import boot_cfg_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYCLES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire strap_bundle_type strap_pins,
  input wire fuse_bundle_type fuse_word,
  input wire logic fuse_valid,
  output boot_mode_type boot_mode,
  output debug_src_type debug_source,
  output xtal_type crystal_select,
  output logic config_done,
  output logic strap_pins_released
);

  localparam int CNT_W = $clog2(HOLD_CYCLES + 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);

  typedef struct packed {
    cfg_state_type state;
    logic [CNT_W-1:0] hold_cnt;
    strap_bundle_type strap;
    fuse_bundle_type fuse;
    boot_mode_type boot;
    debug_src_type dbg;
    xtal_type xtal;
    logic done;
    logic release_en;
    logic pins_free;
    logic [31:0] rdata;
  } top_state_type;

  localparam top_state_type RST_STATE = '{
    state: ST_HOLD,
    hold_cnt: '0,
    strap: '0,
    fuse: '0,
    boot: BOOT_RST,
    dbg: DBG_RST,
    xtal: XTAL_RST,
    done: 1'b0,
    release_en: CTRL_RELEASE_RST,
    pins_free: 1'b0,
    rdata: '0
  };

  top_state_type s_q;
  top_state_type s_d;
  strap_bundle_type sync_level;
  logic sync_stable;
  boot_mode_type dec_boot;
  debug_src_type dec_dbg;
  xtal_type dec_xtal;
  logic apb_setup;
  logic apb_access;

  // map hit test, used by the error answer and the unmapped read check
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    return (a == STATUS_OFS) || (a == STRAPS_OFS) ||
           (a == FUSES_OFS) || (a == CTRL_OFS);
  endfunction

  function automatic logic [31:0] read_word(input top_state_type s,
                                            input logic [ADDR_W-1:0] a);
    logic [31:0] w;
    w = '0;
    unique case (1'b1)
      (a == STATUS_OFS): w = {22'h0, s.boot, s.xtal, s.dbg, s.done};
      (a == STRAPS_OFS): w = {27'h0, s.strap};
      (a == FUSES_OFS): w = {25'h0, s.fuse};
      (a == CTRL_OFS): w = {31'h0, s.release_en};
      default: w = '0;
    endcase
    return w;
  endfunction

  strap_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins(strap_pins),
    .level(sync_level),
    .stable(sync_stable)
  );

  // decode looks only at latched copies, never at live pins
  boot_cfg_decode u_decode (
    .strap(s_q.strap),
    .fuse(s_q.fuse),
    .boot_mode(dec_boot),
    .debug_source(dec_dbg),
    .crystal_select(dec_xtal)
  );

  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;

  // sequencer and register file next state
  always_comb begin
    s_d = s_q;
    unique case (s_q.state)
      ST_HOLD: begin
        if (s_q.hold_cnt == HOLD_LAST) begin
          s_d.state = ST_CAPTURE;
        end else begin
          s_d.hold_cnt = CNT_W'(s_q.hold_cnt + 1'b1);
        end
      end
      ST_CAPTURE: begin
        if (sync_stable) begin
          s_d.strap = sync_level;
          s_d.state = ST_FUSE;
        end
      end
      ST_FUSE: begin
        // fuse bits are taken once; later changes are not seen
        if (fuse_valid) begin
          s_d.fuse = fuse_word;
          s_d.state = ST_DECODE;
        end
      end
      ST_DECODE: begin
        s_d.boot = dec_boot;
        s_d.dbg = dec_dbg;
        s_d.xtal = dec_xtal;
        s_d.done = 1'b1;
        s_d.state = ST_DONE;
      end
      ST_DONE: begin
        s_d.state = ST_DONE;
      end
      default: begin
        // a corrupt state code restarts the whole capture
        s_d = RST_STATE;
      end
    endcase
    // read data is fetched in the setup cycle so the access needs no wait
    if (apb_setup && !pwrite) begin
      s_d.rdata = read_word(s_q, paddr);
    end
    if (apb_access && pwrite && (paddr == CTRL_OFS) && pstrb[0]) begin
      s_d.release_en = pwdata[CTRL_RELEASE_BIT];
    end
    s_d.pins_free = s_d.done && s_d.release_en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // zero wait state slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_hit(paddr);
  assign prdata = s_q.rdata;

  assign boot_mode = s_q.boot;
  assign debug_source = s_q.dbg;
  assign crystal_select = s_q.xtal;
  assign config_done = s_q.done;
  assign strap_pins_released = s_q.pins_free;

  // cycles since reset, saturating, for the timing checks only
  logic [CNT_W+2:0] since_rst_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_rst_q <= '0;
    end else if (!(&since_rst_q)) begin
      since_rst_q <= (CNT_W+3)'(since_rst_q + 1'b1);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  done_timing_a: assert property (
    $rose(config_done) |-> since_rst_q > (CNT_W+3)'(HOLD_CYCLES))
    else $error("decode finished before strap hold window");

  strap_choice_a: assert property (
    config_done && !s_q.fuse.pad_debug_disable_fuse &&
    !s_q.fuse.usb_debug_disable_fuse && boot_mode != BOOT_DL1 |->
    debug_source == ((!s_q.fuse.strap_enable_fuse ||
                      s_q.strap.debug_source_strap) ? DBG_USB : DBG_PINS))
    else $error("debug source disagrees with strap and enable fuse");

  debug_off_a: assert property (
    config_done && s_q.fuse.pad_debug_disable_fuse &&
    s_q.fuse.usb_debug_disable_fuse |-> debug_source == DBG_OFF)
    else $error("debug not disabled with both disable fuses set");

  dl1_no_usb_a: assert property (
    config_done && boot_mode == BOOT_DL1 |->
    debug_source == (s_q.fuse.pad_debug_disable_fuse ? DBG_OFF : DBG_PINS))
    else $error("usb debug allowed in download mode 1");

  xtal_legal_a: assert property (
    crystal_select == XTAL_40 || crystal_select == XTAL_48)
    else $error("crystal selection is not a legal frequency");

  flash_parity_a: assert property (
    config_done && boot_mode == BOOT_FLASH |->
    crystal_select == (odd_ones(s_q.fuse.crystal_high_select_fuse) ?
                       XTAL_48 : XTAL_40))
    else $error("flash boot crystal disagrees with fuse parity");

  dl_parity_a: assert property (
    config_done && boot_mode != BOOT_FLASH &&
    s_q.fuse.crystal_select_source_fuse |->
    crystal_select == (odd_ones(s_q.fuse.crystal_high_select_fuse) ?
                       XTAL_48 : XTAL_40))
    else $error("download boot crystal disagrees with fuse parity");

  dl_strap_a: assert property (
    config_done && boot_mode != BOOT_FLASH &&
    !s_q.fuse.crystal_select_source_fuse |->
    crystal_select == (s_q.strap.crystal_strap ? XTAL_48 : XTAL_40))
    else $error("download boot crystal disagrees with strap");

  strap_hold_a: assert property (
    s_q.state == ST_FUSE || s_q.state == ST_DECODE || s_q.state == ST_DONE
    |=> $stable(s_q.strap))
    else $error("latched strap changed after capture");

  boot_decode_a: assert property (
    config_done |-> (s_q.strap.boot_strap_c ? boot_mode == BOOT_FLASH :
                     s_q.strap.boot_strap_b ? boot_mode == BOOT_DL0 :
                     !s_q.strap.boot_strap_a ? boot_mode == BOOT_DL1 :
                     boot_mode == BOOT_UNDEF))
    else $error("boot mode disagrees with latched straps");

  outputs_frozen_a: assert property (
    config_done |=> config_done && $stable(debug_source) &&
    $stable(crystal_select) && $stable(boot_mode))
    else $error("decoded outputs changed after decode");

  fuse_to_done_a: assert property (
    s_q.state == ST_FUSE && fuse_valid |=> !config_done ##1 config_done)
    else $error("decode not registered one cycle after fuse read");

  hold_window_a: assert property (
    s_q.state == ST_HOLD && s_q.hold_cnt != HOLD_LAST |=>
    s_q.state == ST_HOLD)
    else $error("strap capture started before hold window ended");

  capture_wait_a: assert property (
    s_q.state == ST_CAPTURE && !sync_stable |=> s_q.state == ST_CAPTURE)
    else $error("straps captured while synchroniser unsettled");

  pins_held_a: assert property (
    !config_done |-> !strap_pins_released)
    else $error("strap pins released before configuration done");

  ctrl_mask_a: assert property (
    apb_access && pwrite && !pstrb[0] |=> $stable(s_q.release_en))
    else $error("release enable changed by a write without strobe");

  boot_onehot_a: assert property (
    $onehot(boot_mode))
    else $error("boot mode code is not one hot");

  debug_legal_a: assert property (
    debug_source == DBG_USB || debug_source == DBG_PINS ||
    debug_source == DBG_OFF)
    else $error("debug source is not a legal selection");

  rdata_hold_a: assert property (
    !(apb_setup && !pwrite) |=> $stable(prdata))
    else $error("read data changed outside a read setup");

  unmapped_zero_a: assert property (
    apb_setup && !pwrite && !addr_hit(paddr) |=> prdata == 32'h0)
    else $error("unmapped read returned nonzero data");

  slverr_phase_a: assert property (
    !apb_access |-> !pslverr)
    else $error("slave error outside an access phase");

endmodule

/* rtl/boot_cfg_pkg.sv */
/*
  Shared types, constants and decode helpers for the boot-time strap and
  fuse configuration decoder. Assumes one 40 MHz clock and a fuse array that
  presents its bits together with a valid level once its read is finished.
*/
// Functional notes
// - debug source decided at boot from debug strap and three debug fuses.
// - no disable fuses: strap-enable 0 gives USB; else strap picks USB/pins.
// - pad fuse 0, usb 1: pins; pad 1: USB if allowed; both 1: off.
// - download mode 1 forbids USB debug; pins only, off if pad disabled.
// - crystal setting is only ever 40 MHz or 48 MHz.
// - flash boot: crystal from fuse field parity, even 40, odd 48.
// - download boot, source fuse 1: fuse parity picks 40 or 48 MHz.
// - download boot, source fuse 0: crystal strap 0 gives 40, 1 gives 48.
// - straps latched once after reset, held until next reset, pins freed.
// - boot mode: c=1 flash, b=1 c=0 download 0, all zero download 1.
package boot_cfg_pkg;

  // clock rate and strap hold window
  localparam int CLK_KHZ = 40000;
  localparam int HOLD_TIME_MS = 3;
  // least time, exact at this rate, so no rounding needed
  localparam int HOLD_CYCLES_DEF = HOLD_TIME_MS * CLK_KHZ;
  localparam int SYNC_FILL_W = 3;

  // fuse field width of the crystal high select count
  localparam int XTAL_SEL_W = 3;

  // register map, byte addresses on the apb port
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STRAPS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] FUSES_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h0c;
  localparam int CTRL_RELEASE_BIT = 0;
  localparam logic CTRL_RELEASE_RST = 1'b1;

  typedef struct packed {
    logic debug_source_strap;
    logic crystal_strap;
    logic boot_strap_c;
    logic boot_strap_b;
    logic boot_strap_a;
  } strap_bundle_type;

  typedef struct packed {
    logic pad_debug_disable_fuse;
    logic usb_debug_disable_fuse;
    logic strap_enable_fuse;
    logic crystal_select_source_fuse;
    logic [XTAL_SEL_W-1:0] crystal_high_select_fuse;
  } fuse_bundle_type;

  typedef enum logic [3:0] {
    BOOT_FLASH = 4'b0001,
    BOOT_DL0 = 4'b0010,
    BOOT_DL1 = 4'b0100,
    BOOT_UNDEF = 4'b1000
  } boot_mode_type;

  typedef enum logic [2:0] {
    DBG_USB = 3'b001,
    DBG_PINS = 3'b010,
    DBG_OFF = 3'b100
  } debug_src_type;

  typedef enum logic [1:0] {
    XTAL_40 = 2'b01,
    XTAL_48 = 2'b10
  } xtal_type;

  typedef enum logic [4:0] {
    ST_HOLD = 5'b00001,
    ST_CAPTURE = 5'b00010,
    ST_FUSE = 5'b00100,
    ST_DECODE = 5'b01000,
    ST_DONE = 5'b10000
  } cfg_state_type;

  // values shown before the decode completes
  localparam boot_mode_type BOOT_RST = BOOT_FLASH;
  localparam debug_src_type DBG_RST = DBG_OFF;
  localparam xtal_type XTAL_RST = XTAL_40;

  // odd count of ones in the crystal select field
  function automatic logic odd_ones(input logic [XTAL_SEL_W-1:0] v);
    return ^v;
  endfunction

  // crystal choice from the fuse field parity
  function automatic xtal_type parity_xtal(input logic [XTAL_SEL_W-1:0] v);
    return odd_ones(v) ? XTAL_48 : XTAL_40;
  endfunction

endpackage

/* rtl/strap_sync.sv */
/*
  Three-stage synchroniser for the strap pin levels. Assumes the pins are
  asynchronous to pclk; a level is reported stable once the second and third
  stages agree and the chain has been filled since reset.
*/
module strap_sync
  import boot_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire strap_bundle_type pins,
  output strap_bundle_type level,
  output logic stable
);

  typedef struct packed {
    strap_bundle_type s1;
    strap_bundle_type s2;
    strap_bundle_type s3;
    logic [SYNC_FILL_W-1:0] fill;
  } sync_state_type;

  sync_state_type s_q;
  sync_state_type s_d;

  // shift chain; s1 feeds only s2 to keep the metastable stage isolated
  always_comb begin
    s_d = s_q;
    s_d.s1 = pins;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.fill = {s_q.fill[SYNC_FILL_W-2:0], 1'b1};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // reset zeros would look stable, so wait for the chain to fill
  assign level = s_q.s3;
  assign stable = s_q.fill[SYNC_FILL_W-1] && (s_q.s2 == s_q.s3);

endmodule

/* rtl/boot_cfg_decode.sv */
/*
  Combinational decode of boot mode, debug source and crystal frequency from
  latched straps and fuse bits. Assumes both inputs are already registered and
  steady; its outputs are sampled once by the sequencer.
*/
module boot_cfg_decode
  import boot_cfg_pkg::*;
(
  input wire strap_bundle_type strap,
  input wire fuse_bundle_type fuse,
  output boot_mode_type boot_mode,
  output debug_src_type debug_source,
  output xtal_type crystal_select
);

  logic usb_ok;

  always_comb begin
    if (strap.boot_strap_c) begin
      boot_mode = BOOT_FLASH;
    end else if (strap.boot_strap_b) begin
      boot_mode = BOOT_DL0;
    end else if (!strap.boot_strap_a) begin
      boot_mode = BOOT_DL1;
    end else begin
      boot_mode = BOOT_UNDEF;
    end
  end

  assign usb_ok = !fuse.usb_debug_disable_fuse && (boot_mode != BOOT_DL1);

  always_comb begin
    if (fuse.pad_debug_disable_fuse) begin
      debug_source = usb_ok ? DBG_USB : DBG_OFF;
    end else if (!usb_ok) begin
      debug_source = DBG_PINS;
    end else if (!fuse.strap_enable_fuse) begin
      debug_source = DBG_USB;
    end else begin
      debug_source = strap.debug_source_strap ? DBG_USB : DBG_PINS;
    end
  end

  always_comb begin
    if (boot_mode == BOOT_FLASH || fuse.crystal_select_source_fuse) begin
      crystal_select = parity_xtal(fuse.crystal_high_select_fuse);
    end else begin
      crystal_select = strap.crystal_strap ? XTAL_48 : XTAL_40;
    end
  end

endmodule

/* verif/strap_fuse_model.sv */
/*
  Board strap drivers and fuse array for the boot decoder bench.
  Assumes the bench sets wanted strap and fuse values while reset is held.
*/
module strap_fuse_model
  import boot_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire strap_bundle_type strap_set,
  input wire fuse_bundle_type fuse_set,
  input wire logic [1:0] fuse_wait,
  input wire logic pins_released,
  output strap_bundle_type strap_pins,
  output fuse_bundle_type fuse_word,
  output logic fuse_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] age_q;
  logic flip_q;
  // cycles since reset release, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= 8'h00;
      flip_q <= 1'b0;
    end else begin
      if (age_q != 8'hff) age_q <= age_q + 8'h01;
      flip_q <= ~flip_q;
    end
  end
  // read ends after a variable wait, always after strap capture
  assign fuse_valid = age_q >= 8'h0a + {4'h0, fuse_wait, 2'b00};
  // unread fuse bits are garbage that changes every cycle
  assign fuse_word = (fuse_valid || flip_q) ? fuse_set : ~fuse_set;
  // board drives levels
  // freed pins carry ordinary traffic, so they toggle
  assign strap_pins = (pins_released && flip_q) ? ~strap_set : strap_set;
endmodule

/* verif/boot_strap_fuse_config_decoder_test.sv */
/*
  Self-checking bench for the boot configuration decoder: every boot mode
  and debug fuse mix, random rest. Assumes the strap_fuse_model partner.
*/
module boot_strap_fuse_config_decoder_test
  import boot_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr, fuse_valid, config_done, released;
  logic seen_done = 1'b0;
  logic [1:0] fuse_wait = 2'b00;
  strap_bundle_type strap_pins;
  strap_bundle_type strap_set = '0;
  fuse_bundle_type fuse_word;
  fuse_bundle_type fuse_set = '0;
  boot_mode_type boot_mode;
  debug_src_type debug_source;
  xtal_type crystal_select;
  int num_errors = 0;
  int samples_checked = 0;
  logic [31:0] exp_q[$];

  boot_cfg_top #(.HOLD_CYCLES(8)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strap_pins(strap_pins), .fuse_word(fuse_word),
    .fuse_valid(fuse_valid), .boot_mode(boot_mode),
    .debug_source(debug_source), .crystal_select(crystal_select),
    .config_done(config_done), .strap_pins_released(released));
  strap_fuse_model model_u (.pclk(pclk), .presetn(presetn),
    .strap_set(strap_set), .fuse_set(fuse_set), .fuse_wait(fuse_wait),
    .pins_released(released), .strap_pins(strap_pins),
    .fuse_word(fuse_word), .fuse_valid(fuse_valid));

  // 40 MHz
  always #12.5 pclk = ~pclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [31:0] pop();
    if (exp_q.size() == 0) return 'x;
    return exp_q.pop_front();
  endfunction

  // expected {boot mode, debug source, crystal}
  function automatic logic [8:0] expect_cfg(strap_bundle_type s,
                                            fuse_bundle_type f);
    boot_mode_type b;
    debug_src_type d;
    logic odd;
    b = s.boot_strap_c ? BOOT_FLASH : s.boot_strap_b ? BOOT_DL0 :
        !s.boot_strap_a ? BOOT_DL1 : BOOT_UNDEF;
    if (b == BOOT_DL1) d = f.pad_debug_disable_fuse ? DBG_OFF : DBG_PINS;
    else if (f.pad_debug_disable_fuse) begin
      d = f.usb_debug_disable_fuse ? DBG_OFF : DBG_USB;
    end else if (f.usb_debug_disable_fuse) d = DBG_PINS;
    else if (!f.strap_enable_fuse || s.debug_source_strap) d = DBG_USB;
    else d = DBG_PINS;
    odd = (b == BOOT_FLASH || f.crystal_select_source_fuse) ?
          ^f.crystal_high_select_fuse : s.crystal_strap;
    return {b, d, odd ? XTAL_48 : XTAL_40};
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    if (!wr) exp_q.push_back(d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the slave; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    check(32'(pslverr), 32'(a > CTRL_OFS));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input int i);
    strap_bundle_type st;
    fuse_bundle_type fu;
    logic [8:0] e;
    logic [31:0] stat;
    int n;
    st = strap_bundle_type'(5'($urandom));
    fu = fuse_bundle_type'(7'($urandom));
    st[2:0] = i[2:0];
    fu[6:4] = i[5:3];
    n = 0;
    @(posedge pclk);
    presetn <= 1'b0;
    strap_set <= st;
    fuse_set <= fu;
    fuse_wait <= 2'($urandom);
    repeat (4) @(posedge pclk);
    check(32'({boot_mode, debug_source, crystal_select, config_done}),
          32'({BOOT_RST, DBG_RST, XTAL_RST, 1'b0}));
    e = expect_cfg(st, fu);
    stat = {22'h0, e[8:5], e[1:0], e[4:2], 1'b1};
    exp_q.push_back(32'(e));
    presetn <= 1'b1;
    while (config_done !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200) num_errors++;
    apb(1'b0, STATUS_OFS, stat);
    apb(1'b0, STRAPS_OFS, 32'(st));
    apb(1'b0, FUSES_OFS, 32'(fu));
    apb(1'b0, 8'h10, 32'h0);
    apb(1'b1, STATUS_OFS, 32'hffff_ffff);
    // strobe for bit 0 off: the write must be ignored
    pstrb <= 4'he;
    apb(1'b1, CTRL_OFS, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, CTRL_OFS, 32'h1);
    check(32'(released), 32'h1);
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b0, CTRL_OFS, 32'h0);
    check(32'(released), 32'h0);
    apb(1'b0, STRAPS_OFS, 32'(st));
    apb(1'b0, STATUS_OFS, stat);
  endtask

  // read data and decoded settings against the oldest note
  always @(posedge pclk) begin
    // zero wait states: every access phase is answered at once
    if (psel && penable)
      check(32'(pready), 32'h1);
    if (psel && penable && pready && !pwrite)
      check(prdata, pop());
    if (!presetn) seen_done <= 1'b0;
    else if (config_done && !seen_done) begin
      seen_done <= 1'b1;
      check(32'({boot_mode, debug_source, crystal_select}), pop());
    end
  end

  // main sequence: all boot mode and debug fuse mixes
  initial begin
    void'($urandom(32'h99d1));
    for (int i = 0; i < 64; i++) run(i);
    end_of_test();
  end

  // a hang counts as a failure
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_of_test();
  end
endmodule
